// ---- adcr_pkg.sv ----
// Shared constants for the A/D converter control block.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package adcr_pkg;
  localparam logic [11:0] ADCR_OFF_RES_LO = 12'h000;
  localparam logic [11:0] ADCR_OFF_RES_HI = 12'h004;
  localparam logic [11:0] ADCR_OFF_CTL_A = 12'h008;
  localparam logic [11:0] ADCR_OFF_CTL_B = 12'h00c;
  localparam logic [11:0] ADCR_OFF_PIN_EN = 12'h010;
  localparam logic [11:0] ADCR_OFF_STATUS = 12'h014;
  localparam logic [11:0] ADCR_OFF_IRQ_EN = 12'h018;
  // Field positions inside the first control register.
  localparam int ADCR_BIT_START = 7;
  localparam int ADCR_BIT_BUSY = 6;
  localparam int ADCR_BIT_EN = 5;
  localparam int ADCR_BIT_ALIGN = 4;
  localparam int ADCR_RES_W = 12;
  localparam int ADCR_DEF_CONV_CYC = 16;
  localparam logic [7:0] ADCR_RST_BYTE = 8'h00;
  localparam logic [2:0] ADCR_SRC_BANDGAP = 3'h1;
  localparam logic [1:0] ADCR_REF_SUPPLY = 2'h1;
  typedef enum logic [1:0] {
    ADCR_ST_IDLE = 2'b00,
    ADCR_ST_ARMED = 2'b01,
    ADCR_ST_CONV = 2'b11
  } adcr_state_t;
  typedef enum logic [1:0] {
    ADCR_SEL_EXT = 2'b00,
    ADCR_SEL_BG = 2'b01,
    ADCR_SEL_GND = 2'b10
  } adcr_src_t;
endpackage : adcr_pkg

// ---- adcr_result_mem.sv ----
// Two-byte result store for the A/D block, with registered read data.
// Assumes write and read requests are synchronous to the core clock.
`timescale 1ns/1ns
module adcr_result_mem #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_hi,
  input wire logic [WIDTH-1:0] wr_lo,
  input wire logic rd_sel_hi,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_reg [0:1];

  // Both bytes load together so software never sees a torn result.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
    end else if (clk_en && wr_en) begin
      mem_reg[0] <= wr_lo;
      mem_reg[1] <= wr_hi;
    end
  end

  // Read data is registered; it trails the select by one cycle.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else if (clk_en) begin
      rd_data <= rd_sel_hi ? mem_reg[1] : mem_reg[0];
    end
  end
endmodule : adcr_result_mem

// ---- adcr_top.sv ----
// Control registers, start sequencing and result formatting for a 12-bit A/D unit.
// Assumes an APB master on core_clk and an analog core that delivers its code
// on conv_data, valid at the tick where the internal conversion count runs out.
//
// Notes on behaviour
// - Result is twelve bits, from an external pin or the internal reference.
// - Align bit zero: high byte holds bits 11..4, low byte upper nibble 3..0.
// - Align bit one: high byte low nibble 11..8, low byte bits 7..0.
// - Result byte positions not holding data read as zero.
// - Converter disabled keeps result bytes unchanged and powers it down.
// - Writing start bit high then low begins a conversion.
// - Busy flag sets when conversion begins, clears at completion.
// - Enable bit five powers the converter; software sets it first.
// - Channel codes 0..7 pick analog inputs; top bit set selects none.
// - Source 000 and 101..111 external, 001 bandgap, 010..100 ground.
// - Reference code 01 uses supply; 00 and 1x use the reference pin.
// - Conversion clock is system clock divided by two to the code.
// - Pin enable makes pin analog, drops digital function and pull-high.
// - Completion sets an interrupt request flag, raised if enabled.
// - Pin enable overrides the port direction setting.
`timescale 1ns/1ns
module adcr_top
  import adcr_pkg::*;
#(
  parameter int CONV_CYCLES = adcr_pkg::ADCR_DEF_CONV_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [adcr_pkg::ADCR_RES_W-1:0] conv_data,
  output logic conv_power_on,
  output logic conv_sample,
  output logic conv_clk_tick,
  output logic [7:0] ext_input_route,
  output logic bandgap_route,
  output logic ground_route,
  output logic ref_from_supply,
  output logic [7:0] analog_pin_enable_bits,
  output logic [7:0] pin_digital_off,
  output logic conv_irq
);
  import adcr_pkg::*;

  initial begin
    if (CONV_CYCLES < 2 || CONV_CYCLES > 255) begin
      $error("CONV_CYCLES must be in 2..255");
    end
  end

  logic [7:0] ctl_a_reg;
  logic [7:0] conv_control_b;
  logic irq_flag_reg;
  logic irq_en_reg;
  logic start_seen_reg;
  adcr_state_t state_reg;
  logic [6:0] div_cnt_reg;
  logic [7:0] conv_cnt_reg;
  logic tick;
  logic done;
  logic wr_acc;
  logic rd_acc;
  logic rd_pending_reg;
  logic rd_res_reg;
  logic res_rd;
  logic [7:0] mem_rd;
  logic [11:0] res_code;
  logic [7:0] fmt_hi;
  logic [7:0] fmt_lo;
  logic [2:0] src_code;
  logic [3:0] chan_code;

  // Decodes the input source code into one of the three routes.
  function automatic adcr_src_t src_decode(input logic [2:0] code);
    if (code == ADCR_SRC_BANDGAP) begin
      src_decode = ADCR_SEL_BG;
    end else if (code >= 3'h2 && code <= 3'h4) begin
      src_decode = ADCR_SEL_GND;
    end else begin
      src_decode = ADCR_SEL_EXT;
    end
  endfunction : src_decode

  // Mask of divider bits that must all be one for a conversion clock edge.
  function automatic logic [6:0] div_mask(input logic [2:0] code);
    div_mask = 7'((8'h01 << code) - 8'h01);
  endfunction : div_mask

  // True for every offset that holds a register. Anything else answers with an
  // error so a stray pointer in software shows up instead of reading silence.
  function automatic logic addr_mapped(input logic [11:0] addr);
    if (addr == ADCR_OFF_RES_LO || addr == ADCR_OFF_RES_HI) begin
      addr_mapped = 1'b1;
    end else if (addr == ADCR_OFF_CTL_A || addr == ADCR_OFF_CTL_B) begin
      addr_mapped = 1'b1;
    end else if (addr == ADCR_OFF_PIN_EN || addr == ADCR_OFF_STATUS) begin
      addr_mapped = 1'b1;
    end else if (addr == ADCR_OFF_IRQ_EN) begin
      addr_mapped = 1'b1;
    end else begin
      addr_mapped = 1'b0;
    end
  endfunction : addr_mapped

  // True for the two result bytes, which are read through the result store.
  function automatic logic addr_result(input logic [11:0] addr);
    if (addr == ADCR_OFF_RES_LO || addr == ADCR_OFF_RES_HI) begin
      addr_result = 1'b1;
    end else begin
      addr_result = 1'b0;
    end
  endfunction : addr_result

  assign wr_acc = psel && penable && pwrite && pready;
  assign rd_acc = psel && !penable && !pwrite;
  assign res_rd = rd_acc && addr_result(paddr);
  assign src_code = conv_control_b[7:5];
  assign chan_code = ctl_a_reg[3:0];
  assign tick = (div_cnt_reg & div_mask(conv_control_b[2:0])) ==
                div_mask(conv_control_b[2:0]);
  assign done = (state_reg == ADCR_ST_CONV) && tick && (conv_cnt_reg == 8'h01);

  // Control register A; all eight written bits are stored, but busy reads back from the state.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_a_reg <= ADCR_RST_BYTE;
    end else if (clk_en && wr_acc && paddr == ADCR_OFF_CTL_A) begin
      ctl_a_reg <= pwdata[7:0];
    end
  end

  // Control register B and pin enables.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_control_b <= ADCR_RST_BYTE;
      analog_pin_enable_bits <= ADCR_RST_BYTE;
      irq_en_reg <= 1'b0;
    end else if (clk_en && wr_acc) begin
      if (paddr == ADCR_OFF_CTL_B) begin
        conv_control_b <= pwdata[7:0];
      end else if (paddr == ADCR_OFF_PIN_EN) begin
        analog_pin_enable_bits <= pwdata[7:0];
      end else if (paddr == ADCR_OFF_IRQ_EN) begin
        irq_en_reg <= pwdata[0];
      end
    end
  end

  // Start sequencing: a high-to-low on the start bit while idle begins a run.
  // The armed state tracks a high start bit, so a later low write fires.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ADCR_ST_IDLE;
      conv_cnt_reg <= 8'h00;
      start_seen_reg <= 1'b0;
    end else if (clk_en) begin
      start_seen_reg <= ctl_a_reg[ADCR_BIT_START];
      case (state_reg)
        ADCR_ST_IDLE: begin
          if (ctl_a_reg[ADCR_BIT_START] && ctl_a_reg[ADCR_BIT_EN]) begin
            state_reg <= ADCR_ST_ARMED;
          end
        end
        ADCR_ST_ARMED: begin
          if (!ctl_a_reg[ADCR_BIT_EN]) begin
            state_reg <= ADCR_ST_IDLE;
          end else if (!ctl_a_reg[ADCR_BIT_START]) begin
            state_reg <= ADCR_ST_CONV;
            conv_cnt_reg <= 8'(CONV_CYCLES);
          end
        end
        ADCR_ST_CONV: begin
          // Start writes are not looked at here, so a run cannot restart.
          if (!ctl_a_reg[ADCR_BIT_EN]) begin
            state_reg <= ADCR_ST_IDLE;
          end else if (done) begin
            state_reg <= ADCR_ST_IDLE;
          end else if (tick) begin
            conv_cnt_reg <= conv_cnt_reg - 8'h01;
          end
        end
        default: begin
          state_reg <= ADCR_ST_IDLE;
        end
      endcase
    end
  end

  // Free divider; a conversion clock edge is when its low code bits are all one.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt_reg <= 7'h00;
    end else if (clk_en) begin
      if (ctl_a_reg[ADCR_BIT_EN]) begin
        div_cnt_reg <= div_cnt_reg + 7'h01;
      end else begin
        div_cnt_reg <= 7'h00;
      end
    end
  end

  // Interrupt request flag; set wins over a clear in the same cycle, so a
  // completion that races a software clear is never lost.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_flag_reg <= 1'b0;
    end else if (clk_en) begin
      if (done) begin
        irq_flag_reg <= 1'b1;
      end else if (wr_acc && paddr == ADCR_OFF_STATUS && pwdata[0]) begin
        irq_flag_reg <= 1'b0;
      end
    end
  end

  // Request output; the completion cycle is folded in so the request does not
  // trail the flag that causes it by a cycle.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_irq <= 1'b0;
    end else if (clk_en) begin
      conv_irq <= (irq_flag_reg || done) && irq_en_reg;
    end
  end

  // Formats the core's code for the chosen alignment; spare bits are zero.
  always_comb begin
    res_code = conv_data;
    if (ctl_a_reg[ADCR_BIT_ALIGN]) begin
      fmt_hi = {4'h0, res_code[11:8]};
      fmt_lo = res_code[7:0];
    end else begin
      fmt_hi = res_code[11:4];
      fmt_lo = {res_code[3:0], 4'h0};
    end
  end

  // Result bytes only load on a completed conversion, never while disabled.
  adcr_result_mem #(
    .WIDTH(8)
  ) u_res (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .wr_en(done && ctl_a_reg[ADCR_BIT_EN]),
    .wr_hi(fmt_hi),
    .wr_lo(fmt_lo),
    .rd_sel_hi(paddr == ADCR_OFF_RES_HI),
    .rd_data(mem_rd)
  );

  // The result store answers one cycle after setup, so a result read is marked
  // here and pready waits one access cycle for it; other registers need no wait.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_pending_reg <= 1'b0;
      rd_res_reg <= 1'b0;
    end else if (clk_en) begin
      rd_pending_reg <= psel && !penable;
      rd_res_reg <= res_rd;
    end
  end

  // APB answer: ready in the first access cycle, one cycle later for the result
  // bytes; unmapped addresses error.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (clk_en) begin
      pready <= (psel && !penable && !res_rd) || rd_res_reg;
      pslverr <= psel && !penable && !addr_mapped(paddr);
      prdata <= 32'h00000000;
      if (rd_res_reg) begin
        prdata <= {24'h000000, mem_rd};
      end else if (rd_acc) begin
        if (paddr == ADCR_OFF_CTL_A) begin
          prdata <= {24'h000000, ctl_a_reg[7], state_reg == ADCR_ST_CONV,
                     ctl_a_reg[5:0]};
        end else if (paddr == ADCR_OFF_CTL_B) begin
          prdata <= {24'h000000, conv_control_b};
        end else if (paddr == ADCR_OFF_PIN_EN) begin
          prdata <= {24'h000000, analog_pin_enable_bits};
        end else if (paddr == ADCR_OFF_STATUS) begin
          prdata <= {31'h00000000, irq_flag_reg};
        end else if (paddr == ADCR_OFF_IRQ_EN) begin
          prdata <= {31'h00000000, irq_en_reg};
        end
      end
    end
  end

  // Converter power, busy and tick outputs, registered so the analog side never
  // sees a decode glitch while the state machine moves.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_power_on <= 1'b0;
      conv_sample <= 1'b0;
      conv_clk_tick <= 1'b0;
    end else if (clk_en) begin
      conv_power_on <= ctl_a_reg[ADCR_BIT_EN];
      conv_sample <= state_reg == ADCR_ST_CONV;
      conv_clk_tick <= tick && state_reg == ADCR_ST_CONV;
    end
  end

  // Input routing, reference choice and pin override. At most one input is joined
  // at a time, so a pin is never shorted onto the bandgap or ground.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_input_route <= 8'h00;
      bandgap_route <= 1'b0;
      ground_route <= 1'b0;
      ref_from_supply <= 1'b0;
      pin_digital_off <= 8'h00;
    end else if (clk_en) begin
      ext_input_route <= 8'h00;
      if (src_decode(src_code) == ADCR_SEL_EXT && !chan_code[3]) begin
        ext_input_route <= 8'(8'h01 << chan_code[2:0]);
      end
      bandgap_route <= src_decode(src_code) == ADCR_SEL_BG;
      ground_route <= src_decode(src_code) == ADCR_SEL_GND;
      ref_from_supply <= conv_control_b[4:3] == ADCR_REF_SUPPLY;
      pin_digital_off <= analog_pin_enable_bits;
    end
  end

  // The previous start level is kept for debug visibility of the sequence.
  logic unused_ok;
  assign unused_ok = start_seen_reg ^ rd_pending_reg ^ rd_res_reg ^ (|mem_rd);
endmodule : adcr_top

// ---- adcr_core_model.sv ----
// Behavioural analog core facing adcr_top: a distinct code for each routed input.
// Assumes the route outputs are one-hot or all zero.
`timescale 1ns/1ns
module adcr_core_model (
  input wire logic core_clk,
  input wire logic conv_power_on,
  input wire logic [7:0] ext_input_route,
  input wire logic bandgap_route,
  input wire logic ground_route,
  output logic [11:0] conv_data
);
  logic [11:0] wander_reg = 12'h5a5;
  // Powered down or floating, the data moves every cycle so stale codes show.
  always @(posedge core_clk) wander_reg <= wander_reg + 12'h2b1;
  // Each pin has its own code, so a wrong route gives a wrong result.
  always_comb begin
    conv_data = ~wander_reg;
    if (conv_power_on && bandgap_route) conv_data = 12'h7c3;
    if (conv_power_on && ground_route) conv_data = 12'h000;
    for (int i = 0; i < 8; i++)
      if (conv_power_on && ext_input_route[i]) conv_data = {1'b1, i[2:0], 8'h3c};
  end
endmodule : adcr_core_model

// ---- adcr_top_properties.sv ----
// Port checker for adcr_top: register writes against outputs, busy length.
// Assumes clk_en is held high by the surroundings.
`timescale 1ns/1ns
module adcr_top_properties
  import adcr_pkg::*;
#(
  parameter int CONV_CYCLES = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic conv_power_on,
  input wire logic conv_sample,
  input wire logic conv_clk_tick,
  input wire logic [7:0] ext_input_route,
  input wire logic bandgap_route,
  input wire logic ground_route,
  input wire logic ref_from_supply,
  input wire logic [7:0] analog_pin_enable_bits,
  input wire logic [7:0] pin_digital_off
);
  logic wr;
  logic [8:0] tick_cnt_reg;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  assign wr = psel && penable && pready && pwrite;
  // Ticks of one busy period; cleared when idle so an abort cannot leak in.
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst) tick_cnt_reg <= 9'h000;
    else if (!conv_sample) tick_cnt_reg <= 9'h000;
    else if (conv_clk_tick) tick_cnt_reg <= tick_cnt_reg + 9'h001;
  property p_len;
    $fell(conv_sample) && conv_power_on |-> tick_cnt_reg == 9'(CONV_CYCLES);
  endproperty
  a_len: assert property (p_len) else $error("busy length wrong");
  property p_pow;
    wr && paddr == ADCR_OFF_CTL_A |-> ##2 conv_power_on == $past(pwdata[5], 2);
  endproperty
  a_pow: assert property (p_pow) else $error("enable not followed");
  property p_off;
    !conv_power_on [*2] |-> !conv_sample;
  endproperty
  a_off: assert property (p_off) else $error("busy while off");
  property p_ref;
    wr && paddr == ADCR_OFF_CTL_B |-> ##2 ref_from_supply == ($past(pwdata[4:3], 2) == 2'h1);
  endproperty
  a_ref: assert property (p_ref) else $error("reference wrong");
  property p_src;
    wr && paddr == ADCR_OFF_CTL_B |-> ##2 bandgap_route == ($past(pwdata[7:5], 2) == 3'h1)
      && ground_route == ($past(pwdata[7:5], 2) inside {3'h2, 3'h3, 3'h4});
  endproperty
  a_src: assert property (p_src) else $error("source route wrong");
  property p_one;
    $onehot0({ext_input_route, bandgap_route, ground_route});
  endproperty
  a_one: assert property (p_one) else $error("two inputs joined");
  property p_pin;
    wr && paddr == ADCR_OFF_PIN_EN |-> ##2 analog_pin_enable_bits == $past(pwdata[7:0], 2);
  endproperty
  a_pin: assert property (p_pin) else $error("pin enables wrong");
  property p_dig;
    $changed(analog_pin_enable_bits) |=> pin_digital_off == $past(analog_pin_enable_bits);
  endproperty
  a_dig: assert property (p_dig) else $error("pin override wrong");
  c_conv: cover property ($fell(conv_sample) && conv_power_on);
  c_bg: cover property (bandgap_route);
  c_tick: cover property (conv_clk_tick && conv_sample);
endmodule : adcr_top_properties
bind adcr_top adcr_top_properties #(.CONV_CYCLES(CONV_CYCLES)) chk_u (.core_clk(core_clk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .conv_power_on(conv_power_on),
  .conv_sample(conv_sample), .conv_clk_tick(conv_clk_tick), .ext_input_route(ext_input_route),
  .bandgap_route(bandgap_route), .ground_route(ground_route), .ref_from_supply(ref_from_supply),
  .analog_pin_enable_bits(analog_pin_enable_bits), .pin_digital_off(pin_digital_off));

// ---- tb_top.sv ----
// Self-checking bench for adcr_top over APB with a behavioural analog core.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ns
module tb_top;
  import adcr_pkg::*;
  logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000, conv_data;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, conv_power_on, conv_sample, conv_clk_tick;
  logic bandgap_route, ground_route, ref_from_supply, conv_irq;
  logic [7:0] ext_input_route, analog_pin_enable_bits;
  int err_total = 0, compares = 0, n;
  // Clock at 50 MHz.
  always #10 core_clk = ~core_clk;
  adcr_top #(.CONV_CYCLES(2)) dut_u (.core_clk, .sys_rst, .clk_en(1'b1), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .conv_data, .conv_power_on,
    .conv_sample, .conv_clk_tick, .ext_input_route, .bandgap_route, .ground_route,
    .ref_from_supply, .analog_pin_enable_bits, .pin_digital_off(), .conv_irq);
  adcr_core_model core_u (.core_clk, .conv_power_on, .ext_input_route, .bandgap_route,
    .ground_route, .conv_data);
  task automatic tally_and_finish;
    if (err_total == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t exp %h got %h", $time, e, g);
    end
  endtask : chk
  // One APB transfer; read data is taken at the edge where pready is seen.
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    psel <= 0;
    penable <= 0;
    if (k >= 50) chk(1, 0);
    if (k >= 50) tally_and_finish;
  endtask : apb
  // Waits, under a bound, for the tick or busy output to reach a level.
  task automatic till(input bit tick, input logic v);
    n = 0;
    while ((tick ? conv_clk_tick : conv_sample) !== v) begin
      @(posedge core_clk);
      n++;
      if (n > 3000) chk(v, ~v);
      if (n > 3000) tally_and_finish;
    end
  endtask : till
  task automatic start(input logic [7:0] a);
    apb(1, ADCR_OFF_CTL_A, 8'ha0 | a);
    apb(1, ADCR_OFF_CTL_A, 8'h20 | a);
  endtask : start
  task automatic conv(input logic [7:0] b, input logic [7:0] a, input logic [11:0] c);
    apb(1, ADCR_OFF_CTL_B, b);
    start(a);
    till(0, 1);
    till(0, 0);
    apb(0, ADCR_OFF_RES_HI, 0);
    chk(a[4] ? c[11:8] : c[11:4], rd);
    apb(0, ADCR_OFF_RES_LO, 0);
    chk(a[4] ? c[7:0] : {c[3:0], 4'h0}, rd);
  endtask : conv
  task automatic regs_and_routes;
    apb(0, ADCR_OFF_CTL_B, 0);
    chk(0, rd);
    apb(1, ADCR_OFF_CTL_A, 8'h40);
    apb(0, ADCR_OFF_CTL_A, 0);
    chk(0, rd);
    apb(0, 12'h0fc, 0);
    chk(1, pslverr);
    for (int s = 0; s < 8; s++) begin
      apb(1, ADCR_OFF_CTL_B, {s[2:0], 5'h08});
      apb(1, ADCR_OFF_CTL_A, s == 1 ? 8'h2b : 8'h23);
      apb(0, ADCR_OFF_CTL_B, 0);
      chk({s[2:0], 5'h08}, rd);
      chk(s inside {0, 5, 6, 7} ? 8'h08 : 8'h00, ext_input_route);
      chk({s == 1, s inside {2, 3, 4}}, {bandgap_route, ground_route});
      chk(1, ref_from_supply);
    end
    apb(1, ADCR_OFF_CTL_A, 8'h2b);
    apb(0, ADCR_OFF_CTL_A, 0);
    chk(0, ext_input_route);
  endtask : regs_and_routes
  // Second start mid-conversion, completion flag, then a start while disabled.
  task automatic busy_irq_off;
    apb(1, ADCR_OFF_IRQ_EN, 1);
    apb(1, ADCR_OFF_CTL_B, 8'h07);
    start(8'h01);
    apb(0, ADCR_OFF_CTL_A, 0);
    chk(8'h61, rd);
    start(8'h01);
    apb(0, ADCR_OFF_CTL_A, 0);
    chk(8'h61, rd);
    till(0, 0);
    chk(1, n < 256);
    chk(1, conv_irq);
    apb(0, ADCR_OFF_STATUS, 0);
    chk(1, rd[0]);
    apb(1, ADCR_OFF_STATUS, 1);
    apb(1, ADCR_OFF_CTL_A, 8'h01);
    apb(1, ADCR_OFF_CTL_A, 8'h81);
    apb(1, ADCR_OFF_CTL_A, 8'h01);
    apb(0, ADCR_OFF_CTL_A, 0);
    chk({1'b0, 8'h01}, {conv_irq, rd[7:0]});
    apb(0, ADCR_OFF_RES_HI, 0);
    chk(8'h93, rd);
  endtask : busy_irq_off
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 0;
    regs_and_routes;
    apb(1, ADCR_OFF_PIN_EN, 8'hff);
    conv(8'h03, 8'h05, 12'hd3c);
    conv(8'ha3, 8'h12, 12'ha3c);
    busy_irq_off;
    for (int d = 0; d < 8; d++) begin
      apb(1, ADCR_OFF_CTL_B, d[7:0]);
      start(8'h03);
      till(1, 1);
      @(posedge core_clk);
      till(1, 1);
      chk(1 << d, n + 1);
      till(0, 0);
    end
    apb(1, ADCR_OFF_PIN_EN, 0);
    conv(8'h23, 8'h18, 12'h7c3);
    conv(8'h63, 8'h08, 12'h000);
    tally_and_finish;
  end
endmodule : tb_top
